// ### src/pnsp_pkg.sv
/*
  Package for the pipelined no-turnaround SRAM port: organisation
  constants, pipeline depth, interleaved burst step codes and port state encodings.
  Assumes a single clock domain; included by every design file.
*/
package pnsp_pkg;
  localparam int ADDR_W_DEF   = 21;
  localparam int LANES_DEF    = 2;
  localparam int PARITY_DEF   = 1;
  localparam int LANE_BITS    = 8;
  localparam int BURST_BITS   = 2;
  localparam int PIPE_DEPTH   = 2;
  localparam logic [1:0] BURST_STEP1 = 2'h1;
  localparam logic [1:0] BURST_STEP2 = 2'h2;
  localparam logic [1:0] BURST_STEP3 = 2'h3;
  localparam int MEM_WORDS_DEF = 64;

  typedef enum logic [2:0] {
    PNSP_IDLE  = 3'h1,
    PNSP_READ  = 3'h2,
    PNSP_WRITE = 3'h4
  } pnsp_state_e;
endpackage : pnsp_pkg

// ### src/pnsp_mem.sv
/*
  Byte-lane memory array for the SRAM port. Writes are lane-masked,
  read data is registered. Assumes a single clock; no reset on the array
  since stored contents have no defined power-up value.
*/
`timescale 1ns/1ps
module pnsp_mem
  import pnsp_pkg::*;
#(
  parameter int AW    = 6,
  parameter int LANES = 2,
  parameter int LW    = 9
) (
  input  wire logic                  i_ref_clk,  // clock
  input  wire logic                  i_we,       // write strobe
  input  wire logic [LANES-1:0]      i_lane_we,  // per-lane enables
  input  wire logic [AW-1:0]         i_waddr,    // write address
  input  wire logic [LANES*LW-1:0]   i_wdata,    // write data
  input  wire logic [AW-1:0]         i_raddr,    // read address
  output logic      [LANES*LW-1:0]   o_rdata     // registered read data
);
  logic [LANES-1:0][LW-1:0] rd_lane;

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      // one array per lane so each lane has a single writing process
      logic [LW-1:0] mem [2**AW];
      logic          hit;

      // write-first: a read of the word written on this edge sees the new
      // lane, so a read issued right behind a write stays coherent
      assign hit = i_we && i_lane_we[g] && (i_waddr == i_raddr);

      always_ff @(posedge i_ref_clk) begin
        if (i_we && i_lane_we[g]) begin
          mem[i_waddr] <= i_wdata[g*LW +: LW];
        end
        rd_lane[g] <= hit ? i_wdata[g*LW +: LW] : mem[i_raddr];
      end
    end
  endgenerate

  assign o_rdata = rd_lane;
endmodule : pnsp_mem

// ### src/pnsp_port.sv
/*
  Pipelined no-turnaround SRAM port: decodes the synchronous command pins,
  runs the two-bit burst counter, schedules writes two edges after their
  address and returns reads two edges after their address.
  Assumes the controller holds burst_mode static and idles before sleep.
  The array modelled here is small; only the low address bits index it.
*/
`timescale 1ns/1ps
// Operation
// - chip selects true, load low, write-enable high at enabled edge: new read
// - chip selects true, load low, write low, some lane low: new write
// - load low with any select false deselects; load high keeps deselect
// - load high advances burst address, keeping direction; selects ignored
// - write with all lanes high writes nothing, bus stays undriven
// - clock enable high: edge ignored, command state and address held; sleep synchronizer still samples
// - stalled read keeps bus driven; stalled write performs no write
// - each lane enable covers eight data bits plus its parity bit
// - only lanes with low enables are updated on a write
// - burst mode high: interleaved order, low bits XOR 1, 2, 3
// - burst mode low: linear order, low bits count up and wrap
// - output enable gates read data asynchronously; no drive otherwise
// - sleep request high powers down, contents kept
// - command state changes only on the rising clock edge or when the async reset asserts
module pnsp_port
  import pnsp_pkg::*;
#(
  parameter int ADDR_W  = ADDR_W_DEF,
  parameter int LANES   = LANES_DEF,
  parameter int PARITY  = PARITY_DEF,
  parameter int MEM_AW  = 6,
  localparam int LW     = LANE_BITS + PARITY,
  localparam int DW     = LANES * LW
) (
  input  wire logic              i_ref_clk,            // clock
  input  wire logic              i_rst_n,              // async reset
  input  wire logic              i_clk_en_n,           // clock enable
  input  wire logic              i_chip_sel_n,         // first select
  input  wire logic              i_chip_sel_high,      // second select
  input  wire logic              i_chip_sel_second_n,  // third select
  input  wire logic              i_load_or_advance,    // high = advance
  input  wire logic              i_write_n,            // write enable
  input  wire logic [LANES-1:0]  i_lane_write_n,       // lane enables
  input  wire logic [ADDR_W-1:0] i_address_bus,        // address
  input  wire logic              i_burst_mode,         // 1 interleaved
  input  wire logic              i_out_en_n,           // async out enable
  input  wire logic              i_sleep_request,      // power down
  input  wire logic [DW-1:0]     i_data_bus,           // data bus input
  output logic      [DW-1:0]     o_data_bus,           // data bus output
  output logic                   o_data_bus_oe_n,      // low = driving
  output logic                   o_sleeping            // sleep status
);
  // pipeline slot: what happens on the bus two edges after the command
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [LANES-1:0]  lanes;
    logic [ADDR_W-1:0] addr;
  } pnsp_slot_s;

  typedef struct packed {
    pnsp_state_e       st;
    logic [ADDR_W-1:0] base;
    logic [1:0]        cnt;
    logic              zz1;
    logic              zz2;
    pnsp_slot_s        p1;
    pnsp_slot_s        p2;
  } pnsp_state_s;

  pnsp_state_s s_q;
  pnsp_state_s s_d;

  logic              sel_all;
  logic              zz_active;
  logic [1:0]        low_bits;
  logic [ADDR_W-1:0] cmd_addr;
  logic              cmd_rd;
  logic              cmd_wr;
  logic [LANES-1:0]  cmd_lanes;
  logic              do_wr;
  logic [DW-1:0]     rd_data;

  assign sel_all   = !i_chip_sel_n && i_chip_sel_high
                     && !i_chip_sel_second_n;
  assign zz_active = s_q.zz2;
  assign o_sleeping = s_q.zz2;

  always_comb begin
    s_d       = s_q;
    cmd_rd    = 1'b0;
    cmd_wr    = 1'b0;
    cmd_lanes = '0;
    cmd_addr  = s_q.base;
    low_bits  = s_q.cnt;
    s_d.zz1   = i_sleep_request;
    s_d.zz2   = s_q.zz1;
    // edge ignored while clock enable is high or while asleep
    if (!i_clk_en_n && !zz_active) begin
      s_d.p2 = s_q.p1;
      if (!i_load_or_advance) begin
        if (sel_all) begin
          s_d.base = i_address_bus;
          s_d.cnt  = '0;
          cmd_addr = i_address_bus;
          if (i_write_n) begin
            s_d.st = PNSP_READ;
            cmd_rd = 1'b1;
          end else begin
            s_d.st    = PNSP_WRITE;
            cmd_wr    = 1'b1;
            cmd_lanes = ~i_lane_write_n;
          end
        end else begin
          s_d.st = PNSP_IDLE;
        end
      end else begin
        // selects and write enable ignored; direction kept
        s_d.cnt = s_q.cnt + 2'h1;
        if (i_burst_mode) begin
          unique case (s_d.cnt)
            2'h1:    low_bits = s_q.base[1:0] ^ BURST_STEP1;
            2'h2:    low_bits = s_q.base[1:0] ^ BURST_STEP2;
            2'h3:    low_bits = s_q.base[1:0] ^ BURST_STEP3;
            default: low_bits = s_q.base[1:0];
          endcase
        end else begin
          low_bits = s_q.base[1:0] + s_d.cnt;
        end
        cmd_addr = {s_q.base[ADDR_W-1:BURST_BITS], low_bits};
        unique case (s_q.st)
          PNSP_READ: cmd_rd = 1'b1;
          PNSP_WRITE: begin
            cmd_wr    = 1'b1;
            cmd_lanes = ~i_lane_write_n;
          end
          PNSP_IDLE: cmd_rd = 1'b0;
        endcase
      end
      // all lanes high on a write is an abort: no write, no drive
      s_d.p1.rd    = cmd_rd;
      s_d.p1.wr    = cmd_wr && (|cmd_lanes);
      s_d.p1.lanes = cmd_lanes;
      s_d.p1.addr  = cmd_addr;
    end
  end

  // write happens on the edge where its data is on the bus
  assign do_wr = !i_clk_en_n && !zz_active && s_q.p2.wr;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '{st: PNSP_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // the array reads the slot entering position 2 on the same edge that
  // the older write lands, so it must forward the written lanes
  pnsp_mem #(
    .AW    (MEM_AW),
    .LANES (LANES),
    .LW    (LW)
  ) u_mem (
    .i_ref_clk (i_ref_clk),
    .i_we      (do_wr),
    .i_lane_we (s_q.p2.lanes),
    .i_waddr   (s_q.p2.addr[MEM_AW-1:0]),
    .i_wdata   (i_data_bus),
    .i_raddr   (s_d.p2.addr[MEM_AW-1:0]),
    .o_rdata   (rd_data)
  );

  // read data registered on the edge that moves the read into slot 2;
  // out enable is applied combinationally, so it acts without the clock
  assign o_data_bus      = rd_data;
  assign o_data_bus_oe_n = !(s_q.p2.rd && !i_out_en_n);

  // is structural: widths follow ADDR_W, LANES and PARITY

  read_latency_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (!i_clk_en_n && !zz_active && !i_load_or_advance && sel_all
     && i_write_n) ##1 (!i_clk_en_n && !zz_active) |=> s_q.p2.rd)
    else $error("read not in output slot after two edges");

  stall_hold_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    i_clk_en_n |=> (s_q.p2 == $past(s_q.p2) && s_q.st == $past(s_q.st)))
    else $error("state changed on an ignored edge");

  abort_nodrive_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (!i_clk_en_n && !zz_active && !i_load_or_advance && sel_all
     && !i_write_n && (&i_lane_write_n)) |=> !s_q.p1.wr && !s_q.p1.rd)
    else $error("write abort scheduled a transfer");

  deselect_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (!i_clk_en_n && !zz_active && !i_load_or_advance && !sel_all)
    |=> s_q.st == PNSP_IDLE && !s_q.p1.rd && !s_q.p1.wr)
    else $error("deselect did not idle the port");

  burst_dir_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (!i_clk_en_n && !zz_active && i_load_or_advance
     && s_q.st == PNSP_READ) |=> s_q.p1.rd && s_q.st == PNSP_READ)
    else $error("burst lost its read direction");

  interleave_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (!i_clk_en_n && !zz_active && i_load_or_advance && i_burst_mode
     && s_q.cnt == 2'h0) |=> s_q.p1.addr[1:0] == ($past(s_q.base[1:0])
     ^ 2'h1))
    else $error("interleaved first beat wrong");

  linear_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (!i_clk_en_n && !zz_active && i_load_or_advance && !i_burst_mode
     && s_q.cnt == 2'h1) |=> s_q.p1.addr[1:0] == 2'($past(s_q.base[1:0])
     + 2'h2))
    else $error("linear second beat wrong");

  oe_gate_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (!s_q.p2.rd || i_out_en_n) |-> o_data_bus_oe_n)
    else $error("bus driven outside an enabled read");

  stall_nowrite_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    i_clk_en_n |-> !do_wr)
    else $error("array written on a stalled edge");

  // the checks below look one edge ahead or at the same edge; ignored edges
  // and sleep get their own checks so each failure points at one cause
  stall_addr_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    i_clk_en_n |=> $stable(s_q.base) && $stable(s_q.cnt))
    else $error("burst address moved on an ignored edge");

  pipe_shift_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (!i_clk_en_n && !zz_active) |=> s_q.p2 == $past(s_q.p1))
    else $error("pipeline slot did not advance on a taken edge");

  new_read_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (!i_clk_en_n && !zz_active && !i_load_or_advance && sel_all
     && i_write_n) |=> s_q.p1.rd && s_q.st == PNSP_READ
     && s_q.p1.addr == $past(i_address_bus))
    else $error("new read not started at the external address");

  new_write_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (!i_clk_en_n && !zz_active && !i_load_or_advance && sel_all
     && !i_write_n && !(&i_lane_write_n)) |=> s_q.p1.wr
     && s_q.st == PNSP_WRITE && s_q.p1.addr == $past(i_address_bus))
    else $error("new write not started at the external address");

  write_dir_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (!i_clk_en_n && !zz_active && i_load_or_advance
     && s_q.st == PNSP_WRITE) |=> !s_q.p1.rd && s_q.st == PNSP_WRITE)
    else $error("burst lost its write direction");

  idle_hold_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (!i_clk_en_n && !zz_active && i_load_or_advance
     && s_q.st == PNSP_IDLE) |=> s_q.st == PNSP_IDLE && !s_q.p1.rd
     && !s_q.p1.wr)
    else $error("advance left the deselected state");

  lane_mask_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (!i_clk_en_n && !zz_active && i_load_or_advance
     && s_q.st == PNSP_WRITE) |=> s_q.p1.lanes == ~$past(i_lane_write_n))
    else $error("burst write lanes do not follow the enables");

  oe_read_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (s_q.p2.rd && !i_out_en_n) |-> !o_data_bus_oe_n)
    else $error("enabled read not driving the bus");

  interleave_last_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (!i_clk_en_n && !zz_active && i_load_or_advance && i_burst_mode
     && s_q.cnt == 2'h2) |=> s_q.p1.addr[1:0] == ($past(s_q.base[1:0])
     ^ 2'h3))
    else $error("interleaved last beat wrong");

  linear_wrap_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (!i_clk_en_n && !zz_active && i_load_or_advance && !i_burst_mode
     && s_q.cnt == 2'h3) |=> s_q.p1.addr == $past(s_q.base))
    else $error("linear burst did not wrap to its start");

  sleep_hold_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    zz_active |=> s_q.p2 == $past(s_q.p2) && $stable(s_q.base)
     && $stable(s_q.st))
    else $error("state changed while asleep");

  sleep_sync_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    $past(i_rst_n, 2) |-> o_sleeping == $past(i_sleep_request, 2))
    else $error("sleep status not two edges behind the request");
endmodule : pnsp_port

// ### bench/pnsp_ctrl_model.sv
/*
  Controller-side data driver for the SRAM port bench.
  Assumes the bench flags each taken edge and when write data is due.
*/
`timescale 1ns/1ps
module pnsp_ctrl_model #(
  parameter int DW = 18
) (
  input  wire logic          i_ref_clk,  // clock
  input  wire logic          i_stepped,  // last edge was taken
  input  wire logic          i_wr_due,   // write data due next taken edge
  output logic      [DW-1:0] o_data_bus  // data toward the port
);
  initial o_data_bus = '0;
  // driven off-edge so data is settled long before the port samples it
  always @(negedge i_ref_clk) begin
    if (i_stepped && i_wr_due) begin
      o_data_bus <= DW'({$urandom, $urandom});
    end else if (i_stepped) begin
      o_data_bus <= ~o_data_bus;  // released bus shows no stale value
    end
  end
endmodule : pnsp_ctrl_model

// ### bench/test_pnsp_port.sv
/*
  Random command bench for pnsp_port against a cycle model.
  Assumes default organisation and the controller data model.
*/
`timescale 1ns/1ps
module test_pnsp_port;
  import pnsp_pkg::*;
  localparam int LW = LANE_BITS + PARITY_DEF;
  localparam int DW = LANES_DEF * LW;
  logic          clk = 0, rst_n = 0, cke_n = 1, ld = 0, we_n = 1;
  logic          mode = 0, oen = 1, zz = 0, taken = 0, s1, s2, slp, oe_n;
  logic [2:0]    cs = 3'b101;
  logic [1:0]    lw_n = 2'b11, k, p1l, p2l;
  logic [20:0]   addr = '0;
  logic [5:0]    base, p1a, p2a;
  logic [DW-1:0] dbus, dout, exp_d, mem [64];
  pnsp_state_e   st, p1k, p2k, ok;
  int            n_fail = 0, checked = 0, cyc = 0;
  wire           wr_due = (p2k == PNSP_WRITE);

  always #25 clk = ~clk;

  pnsp_port DUT (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_clk_en_n(cke_n),
    .i_chip_sel_n(cs[2]), .i_chip_sel_high(cs[1]),
    .i_chip_sel_second_n(cs[0]), .i_load_or_advance(ld),
    .i_write_n(we_n), .i_lane_write_n(lw_n), .i_address_bus(addr),
    .i_burst_mode(mode), .i_out_en_n(oen), .i_sleep_request(zz),
    .i_data_bus(dbus), .o_data_bus(dout), .o_data_bus_oe_n(oe_n),
    .o_sleeping(slp)
  );
  pnsp_ctrl_model #(.DW(DW)) ctrl (
    .i_ref_clk(clk), .i_stepped(taken), .i_wr_due(wr_due),
    .o_data_bus(dbus)
  );

  // model: pipeline slots move only on taken edges
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st  = PNSP_IDLE;
      p1k = PNSP_IDLE;
      p2k = PNSP_IDLE;
      ok  = PNSP_IDLE;
      {taken, s1, s2, k} = '0;
    end else begin
      taken = !cke_n && !s2;
      s2 = s1;
      s1 = zz;
      if (taken) begin
        for (int g = 0; g < LANES_DEF; g++) begin
          if (p2k == PNSP_WRITE && !p2l[g]) begin
            mem[p2a][g*LW +: LW] = dbus[g*LW +: LW];
          end
        end
        // read entering slot 2 sees the write that lands on this edge
        if (p1k == PNSP_READ) exp_d = mem[p1a];
        p2k = p1k;
        p2a = p1a;
        p2l = p1l;
        ok  = p2k;
        if (!ld && cs == 3'b010) begin
          st = we_n ? PNSP_READ : PNSP_WRITE;
          base = addr[5:0];
          k = 2'h0;
        end else if (!ld) begin
          st = PNSP_IDLE;
        end else if (st != PNSP_IDLE) begin
          k = k + 2'h1;
        end
        p1a = {base[5:2],
               mode ? base[1:0] ^ k : base[1:0] + k};
        p1k = (st == PNSP_WRITE && &lw_n) ? PNSP_IDLE : st;
        p1l = lw_n;
      end
    end
  end

  always @(negedge clk) if (rst_n) begin
    chk1("oe_n", !(ok == PNSP_READ && !oen), oe_n);
    chk1("sleeping", s2, slp);
    if (ok == PNSP_READ) chkd("rdata", exp_d, dout);
  end

  task automatic chk1(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask : chk1

  task automatic chkd(input string n, input logic [DW-1:0] e,
                      input logic [DW-1:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chkd

  // c: 0-2 read, 3 write, 4 abort, 5 advance, 6 deselect, 7 stall
  task automatic step(input int c, input int a, input logic s);
    @(posedge clk);
    cke_n <= (c == 7);
    ld    <= (c == 5);
    we_n  <= (c == 5) ? 1'($urandom) : !(c == 3 || c == 4);
    cs    <= (c == 5) ? 3'($urandom) :
             3'b010 ^ ((c == 6) ? 3'(1 << ($urandom % 3)) : 3'b000);
    addr  <= (a >= 0) ? 21'(a) : 21'($urandom);
    lw_n  <= (a >= 0) ? 2'b00 : (c == 4) ? 2'b11 :
             2'($urandom % ((c == 5) ? 4 : 3));
    oen   <= 1'($urandom);
    zz    <= s;
  endtask : step

  task automatic conclude();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  // ceiling well above the roughly 1000 cycles the sequence needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      conclude();
    end
  end

  initial begin
    void'($urandom(32'h52d7));
    for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      rst_n <= 1'b0;
      mode  <= 1'(m);
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 64; i++) step(3, i, 1'b0);
      repeat (300) step($urandom % 8, -1, 1'b0);
      // idle two edges before sleep takes hold, then commands are ignored
      for (int i = 0; i < 12; i++) begin
        step((i > 2 && i < 7) ? $urandom % 8 : 6, -1, i < 7);
      end
      repeat (100) step($urandom % 8, -1, 1'b0);
      repeat (3) step(6, -1, 1'b0);
    end
    conclude();
  end
endmodule : test_pnsp_port
